// ===== src/spimc_top.sv
// Function
// - disabled: all four pins released
// - clock pin input as slave, output as master
// - master two-wire: drive mosi, sample miso
// - slave two-wire: sample mosi, drive miso
// - master single-wire: mosi direction follows direction bit
// - slave single-wire: miso direction follows direction bit
// - single-wire: unused data pin released
// - slave: select pin is active-low input
// - master without fault detect: select released
// - master fault detect: fault input or select output
// - deep stop: module reset, inactive
// - light stop: state held, resumes
// - bit 7 enables receive/fault interrupt
// - disable flushes buffers, receive flag, engine; mode fault flag and events held
// - bit 5 enables transmit-empty interrupt
// - five byte-wide software registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module spimc_top (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            ce,
	input  wire logic                            stop_light,
	input  wire logic                            stop_deep,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [spimc_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [spimc_pkg::DATA_W-1:0]    pwdata,
	output var  logic [spimc_pkg::DATA_W-1:0]    prdata,
	output var  logic                            pready,
	output var  logic                            pslverr,
	output var  logic                            irq,
	input  wire logic                            serial_clock_pin_in,
	output var  logic                            serial_clock_pin_out,
	output var  logic                            serial_clock_pin_oe,
	input  wire logic                            mosi_pin_in,
	output var  logic                            mosi_pin_out,
	output var  logic                            mosi_pin_oe,
	input  wire logic                            miso_pin_in,
	output var  logic                            miso_pin_out,
	output var  logic                            miso_pin_oe,
	input  wire logic                            select_n_pin_in,
	output var  logic                            select_n_pin_out,
	output var  logic                            select_n_pin_oe,
	output var  logic                            serial_clock_claim,
	output var  logic                            mosi_claim,
	output var  logic                            miso_claim,
	output var  logic                            select_claim
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0]                   ctl1;
		logic [7:0]                   ctl2;
		logic [7:0]                   baud;
		logic                         rxf;
		logic                         mode_fault_flag;
		logic                         tx_full;
		logic [7:0]                   txbuf;
		logic [7:0]                   rxbuf;
		logic [7:0]                   shreg;
		logic [2:0]                   bitcnt;
		logic [7:0]                   divcnt;
		spimc_pkg::spimc_phase_t      phase;
		logic                         out_bit;
		logic [spimc_pkg::EV_W-1:0]   evt;
		logic [spimc_pkg::EV_W-1:0]   mask;
		logic                         sclk_s1;
		logic                         sclk_s2;
		logic                         sclk_s3;
		logic                         mosi_s1;
		logic                         mosi_s2;
		logic                         miso_s1;
		logic                         miso_s2;
		logic                         ss_s1;
		logic                         ss_s2;
		logic                         pready;
		logic                         pslverr;
		logic [spimc_pkg::DATA_W-1:0] prdata;
		logic                         irq;
		logic                         sclk_out;
		logic                         sclk_oe;
		logic                         mosi_out;
		logic                         mosi_oe;
		logic                         miso_out;
		logic                         miso_oe;
		logic                         ss_out;
		logic                         ss_oe;
		logic                         sclk_claim;
		logic                         mosi_claim;
		logic                         miso_claim;
		logic                         ss_claim;
	} spimc_state_t;

	spimc_state_t s_reg;
	spimc_state_t s_next;

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic spimc_pkg::spimc_sel_t spimc_decode(
		input logic [spimc_pkg::ADDR_W-1:0] addr
	);
		spimc_pkg::spimc_sel_t sel;
		sel = spimc_pkg::SEL_NONE;
		if (addr == spimc_pkg::OFF_CTL1)
			sel = spimc_pkg::SEL_CTL1;
		else if (addr == spimc_pkg::OFF_CTL2)
			sel = spimc_pkg::SEL_CTL2;
		else if (addr == spimc_pkg::OFF_BAUD)
			sel = spimc_pkg::SEL_BAUD;
		else if (addr == spimc_pkg::OFF_STAT)
			sel = spimc_pkg::SEL_STAT;
		else if (addr == spimc_pkg::OFF_DATA)
			sel = spimc_pkg::SEL_DATA;
		else if (addr == spimc_pkg::OFF_EVT)
			sel = spimc_pkg::SEL_EVT;
		else if (addr == spimc_pkg::OFF_MASK)
			sel = spimc_pkg::SEL_MASK;
		return sel;
	endfunction

	function automatic logic [7:0] spimc_status(input spimc_state_t st);
		logic [7:0] v;
		v = 8'h00;
		v[spimc_pkg::ST_RXF]  = st.rxf;
		v[spimc_pkg::ST_TXE]  = !st.tx_full;
		v[spimc_pkg::ST_MODE_FAULT_FLAG] = st.mode_fault_flag;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	spimc_pkg::spimc_sel_t sel;
	logic                  setup;
	logic                  done;
	logic                  en;
	logic                  master;
	logic                  swire;
	logic                  dir;
	logic                  fden;
	logic                  select_output_enable;
	logic                  rise;
	logic                  fall;
	logic                  din;
	logic [7:0]            rd_byte;

	always_comb
	begin
		s_next  = s_reg;
		sel     = spimc_decode(paddr);
		setup   = psel && !penable;
		done    = psel && penable && s_reg.pready;
		en      = s_reg.ctl1[spimc_pkg::C1_EN];
		master  = s_reg.ctl1[spimc_pkg::C1_MSTR];
		swire   = s_reg.ctl1[spimc_pkg::C1_SWIRE];
		select_output_enable    = s_reg.ctl1[spimc_pkg::C1_SELECT_OUTPUT_ENABLE];
		dir     = s_reg.ctl2[spimc_pkg::C2_DIR];
		fden    = s_reg.ctl2[spimc_pkg::C2_FDEN];
		rise    = s_reg.sclk_s2 && !s_reg.sclk_s3;
		fall    = !s_reg.sclk_s2 && s_reg.sclk_s3;
		din     = (master ^ swire) ? s_reg.miso_s2 : s_reg.mosi_s2;
		rd_byte = 8'h00;
		if (!ce)
			s_next = s_reg;
		else if (stop_deep)
			s_next = '0;
		else if (stop_light)
			s_next = s_reg;
		else
		begin
			// pin synchronisers
			s_next.sclk_s1 = serial_clock_pin_in;
			s_next.sclk_s2 = s_reg.sclk_s1;
			s_next.sclk_s3 = s_reg.sclk_s2;
			s_next.mosi_s1 = mosi_pin_in;
			s_next.mosi_s2 = s_reg.mosi_s1;
			s_next.miso_s1 = miso_pin_in;
			s_next.miso_s2 = s_reg.miso_s1;
			s_next.ss_s1   = select_n_pin_in;
			s_next.ss_s2   = s_reg.ss_s1;

			// read and CTL1-write side effects, cleared before events so a set wins
			if (done && !pwrite && sel == spimc_pkg::SEL_DATA)
				s_next.rxf = 1'b0;
			if (done && !pwrite && sel == spimc_pkg::SEL_EVT)
				s_next.evt = '0;
			if (done && pwrite && sel == spimc_pkg::SEL_CTL1)
				s_next.mode_fault_flag = 1'b0;

			// shift engine
			if (!en)
			begin
				s_next.rxf     = 1'b0;
				s_next.tx_full = 1'b0;
				s_next.txbuf   = 8'h00;
				s_next.rxbuf   = 8'h00;
				s_next.shreg   = 8'h00;
				s_next.bitcnt  = 3'h0;
				s_next.divcnt  = 8'h00;
				s_next.phase   = spimc_pkg::PH_IDLE;
				s_next.out_bit = 1'b0;
			end
			else if (master)
			begin
				if (fden && !select_output_enable && !s_reg.ss_s2)
				begin
					s_next.mode_fault_flag                   = 1'b1;
					s_next.evt[spimc_pkg::EV_MODE_FAULT_FLAG] = 1'b1;
					s_next.phase                  = spimc_pkg::PH_IDLE;
				end
				else
				begin
					case (s_reg.phase)
						spimc_pkg::PH_IDLE:
							if (s_reg.tx_full)
							begin
								s_next.shreg                  = s_reg.txbuf;
								s_next.out_bit                = s_reg.txbuf[7];
								s_next.tx_full                = 1'b0;
								s_next.evt[spimc_pkg::EV_TXE] = 1'b1;
								s_next.bitcnt                 = 3'h0;
								s_next.divcnt                 = 8'h00;
								s_next.phase                  = spimc_pkg::PH_LOW;
							end
						spimc_pkg::PH_LOW:
							if (s_reg.divcnt == s_reg.baud)
							begin
								s_next.divcnt = 8'h00;
								s_next.shreg  = {s_reg.shreg[6:0], din};
								s_next.phase  = spimc_pkg::PH_HIGH;
							end
							else
								s_next.divcnt = s_reg.divcnt + spimc_pkg::DIV_ONE;
						spimc_pkg::PH_HIGH:
							if (s_reg.divcnt == s_reg.baud)
							begin
								s_next.divcnt = 8'h00;
								s_next.bitcnt = s_reg.bitcnt + spimc_pkg::CNT_ONE;
								if (s_reg.bitcnt == spimc_pkg::LAST_BIT)
								begin
									s_next.rxbuf                 = s_reg.shreg;
									s_next.rxf                   = 1'b1;
									s_next.evt[spimc_pkg::EV_RX] = 1'b1;
									s_next.phase                 = spimc_pkg::PH_IDLE;
								end
								else
								begin
									s_next.out_bit = s_reg.shreg[7];
									s_next.phase   = spimc_pkg::PH_LOW;
								end
							end
							else
								s_next.divcnt = s_reg.divcnt + spimc_pkg::DIV_ONE;
						default:
							s_next.phase = spimc_pkg::PH_IDLE;
					endcase
				end
			end
			else if (s_reg.ss_s2)
			begin
				s_next.phase  = spimc_pkg::PH_IDLE;
				s_next.bitcnt = 3'h0;
			end
			else if (s_reg.phase == spimc_pkg::PH_IDLE)
			begin
				s_next.shreg   = s_reg.tx_full ? s_reg.txbuf : 8'h00;
				s_next.out_bit = s_reg.tx_full && s_reg.txbuf[7];
				if (s_reg.tx_full)
					s_next.evt[spimc_pkg::EV_TXE] = 1'b1;
				s_next.tx_full = 1'b0;
				s_next.phase   = spimc_pkg::PH_LOW;
			end
			else
			begin
				if (rise)
				begin
					s_next.shreg  = {s_reg.shreg[6:0], din};
					s_next.bitcnt = s_reg.bitcnt + spimc_pkg::CNT_ONE;
					if (s_reg.bitcnt == spimc_pkg::LAST_BIT)
					begin
						s_next.rxbuf                 = {s_reg.shreg[6:0], din};
						s_next.rxf                   = 1'b1;
						s_next.evt[spimc_pkg::EV_RX] = 1'b1;
						s_next.phase                 = spimc_pkg::PH_IDLE;
					end
				end
				if (fall)
					s_next.out_bit = s_reg.shreg[7];
			end

			// register writes
			if (done && pwrite)
			begin
				if (sel == spimc_pkg::SEL_CTL1)
					s_next.ctl1 = pwdata[7:0];
				else if (sel == spimc_pkg::SEL_CTL2)
					s_next.ctl2 = pwdata[7:0];
				else if (sel == spimc_pkg::SEL_BAUD)
					s_next.baud = pwdata[7:0];
				else if (sel == spimc_pkg::SEL_DATA && en)
				begin
					s_next.txbuf   = pwdata[7:0];
					s_next.tx_full = 1'b1;
				end
				else if (sel == spimc_pkg::SEL_MASK)
					s_next.mask = pwdata[spimc_pkg::EV_W-1:0];
			end

			// apb answer, one wait-free access phase
			if (sel == spimc_pkg::SEL_CTL1)
				rd_byte = s_reg.ctl1;
			else if (sel == spimc_pkg::SEL_CTL2)
				rd_byte = s_reg.ctl2;
			else if (sel == spimc_pkg::SEL_BAUD)
				rd_byte = s_reg.baud;
			else if (sel == spimc_pkg::SEL_STAT)
				rd_byte = spimc_status(s_reg);
			else if (sel == spimc_pkg::SEL_DATA)
				rd_byte = s_reg.rxbuf;
			else if (sel == spimc_pkg::SEL_EVT)
				rd_byte = {5'h00, s_reg.evt};
			else if (sel == spimc_pkg::SEL_MASK)
				rd_byte = {5'h00, s_reg.mask};
			s_next.pready  = setup;
			s_next.pslverr = setup && sel == spimc_pkg::SEL_NONE;
			s_next.prdata  = (setup && !pwrite) ? {24'h000000, rd_byte} : '0;

			// pin roles
			s_next.sclk_claim = en;
			s_next.mosi_claim = en && (master || !swire);
			s_next.miso_claim = en && (!master || !swire);
			s_next.ss_claim   = en && (!master || fden);
			s_next.sclk_oe    = en && master;
			s_next.sclk_out   = en && master && s_next.phase == spimc_pkg::PH_HIGH;
			s_next.mosi_oe    = en && master && (!swire || dir);
			s_next.mosi_out   = s_next.mosi_oe && s_next.out_bit;
			s_next.miso_oe    = en && !master && (swire ? dir : !s_reg.ss_s2);
			s_next.miso_out   = s_next.miso_oe && s_next.out_bit;
			s_next.ss_oe      = en && master && fden && select_output_enable;
			s_next.ss_out     = s_next.ss_oe && s_next.phase == spimc_pkg::PH_IDLE;

			// interrupt level
			s_next.irq = (s_next.ctl1[spimc_pkg::C1_RXIE] && (s_next.rxf || s_next.mode_fault_flag))
				|| (s_next.ctl1[spimc_pkg::C1_TXIE] && !s_next.tx_full)
				|| (|(s_next.evt & s_next.mask));
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata               = s_reg.prdata;
	assign pready               = s_reg.pready;
	assign pslverr              = s_reg.pslverr;
	assign irq                  = s_reg.irq;
	assign serial_clock_pin_out = s_reg.sclk_out;
	assign serial_clock_pin_oe  = s_reg.sclk_oe;
	assign mosi_pin_out         = s_reg.mosi_out;
	assign mosi_pin_oe          = s_reg.mosi_oe;
	assign miso_pin_out         = s_reg.miso_out;
	assign miso_pin_oe          = s_reg.miso_oe;
	assign select_n_pin_out     = s_reg.ss_out;
	assign select_n_pin_oe      = s_reg.ss_oe;
	assign serial_clock_claim   = s_reg.sclk_claim;
	assign mosi_claim           = s_reg.mosi_claim;
	assign miso_claim           = s_reg.miso_claim;
	assign select_claim         = s_reg.ss_claim;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic run;
	assign run = ce && !stop_light && !stop_deep;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pins_release_a: assert property (
		run && !en |=> !serial_clock_claim && !mosi_claim && !miso_claim && !select_claim
			&& !serial_clock_pin_oe && !mosi_pin_oe && !miso_pin_oe && !select_n_pin_oe)
		else $error("pins not released while disabled");
	clock_dir_a: assert property (
		run && en |=> serial_clock_pin_oe == $past(master))
		else $error("clock pin direction wrong");
	master_pins_a: assert property (
		run && en && master && !swire |=> mosi_pin_oe && !miso_pin_oe && miso_claim)
		else $error("master two-wire pins wrong");
	slave_pins_a: assert property (
		run && en && !master && !swire && !s_reg.ss_s2 |=> miso_pin_oe && !mosi_pin_oe)
		else $error("slave two-wire pins wrong");
	master_shared_a: assert property (
		run && en && master && swire |=> mosi_pin_oe == $past(dir))
		else $error("master shared line direction wrong");
	slave_shared_a: assert property (
		run && en && !master && swire |=> miso_pin_oe == $past(dir))
		else $error("slave shared line direction wrong");
	unused_pin_a: assert property (
		run && en && swire |=> (mosi_claim != miso_claim))
		else $error("unused data pin not released");
	slave_select_a: assert property (
		run && en && !master && !swire && s_reg.ss_s2 |=> !miso_pin_oe && select_claim)
		else $error("slave drives while unselected");
	select_off_a: assert property (
		run && en && master && !fden |=> !select_claim && !select_n_pin_oe)
		else $error("select pin used without fault detect");
	fault_detect_a: assert property (
		run && en && master && fden && !select_output_enable && !s_reg.ss_s2
			|=> s_reg.mode_fault_flag && s_reg.phase == spimc_pkg::PH_IDLE)
		else $error("mode fault not flagged");
	deep_stop_a: assert property (
		ce && stop_deep |=> s_reg.ctl1 == 8'h00 && !irq && !serial_clock_claim)
		else $error("deep stop did not reset");
	light_stop_a: assert property (
		ce && stop_light && !stop_deep |=> $stable(s_reg))
		else $error("light stop changed state");
	rx_irq_a: assert property (
		s_reg.ctl1[spimc_pkg::C1_RXIE] && (s_reg.rxf || s_reg.mode_fault_flag) |-> irq)
		else $error("receive or fault interrupt missing");
	flush_a: assert property (
		run && !en |=> !s_reg.rxf && !s_reg.tx_full && s_reg.phase == spimc_pkg::PH_IDLE)
		else $error("disable did not flush");
	tx_irq_a: assert property (
		s_reg.ctl1[spimc_pkg::C1_TXIE] && !s_reg.tx_full |-> irq)
		else $error("transmit empty interrupt missing");
	data_read_a: assert property (
		run && setup && !pwrite && sel == spimc_pkg::SEL_DATA |=> prdata[7:0] == $past(s_reg.rxbuf))
		else $error("data read wrong");
	irq_quiet_a: assert property (
		!s_reg.ctl1[spimc_pkg::C1_RXIE] && !s_reg.ctl1[spimc_pkg::C1_TXIE] && !(|(s_reg.evt & s_reg.mask))
			|-> !irq)
		else $error("interrupt without enabled cause");

endmodule
`default_nettype wire

// ===== src/spimc_pkg.sv
`default_nettype none
package spimc_pkg;
	// bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFF_CTL1 = 8'h00;
	localparam logic [7:0] OFF_CTL2 = 8'h04;
	localparam logic [7:0] OFF_BAUD = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [7:0] OFF_EVT  = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;
	// control one fields
	localparam int C1_RXIE  = 7;
	localparam int C1_EN    = 6;
	localparam int C1_TXIE  = 5;
	localparam int C1_MSTR  = 4;
	localparam int C1_SELECT_OUTPUT_ENABLE  = 1;
	localparam int C1_SWIRE = 0;
	// control two fields
	localparam int C2_FDEN = 4;
	localparam int C2_DIR  = 3;
	// status fields
	localparam int ST_RXF  = 7;
	localparam int ST_TXE  = 5;
	localparam int ST_MODE_FAULT_FLAG = 4;
	// event and mask fields
	localparam int EV_W    = 3;
	localparam int EV_RX   = 0;
	localparam int EV_MODE_FAULT_FLAG = 1;
	localparam int EV_TXE  = 2;
	// shift engine counts
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] CNT_ONE  = 3'h1;
	localparam logic [7:0] DIV_ONE  = 8'h01;
	// register select codes
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CTL1,
		SEL_CTL2,
		SEL_BAUD,
		SEL_STAT,
		SEL_DATA,
		SEL_EVT,
		SEL_MASK
	} spimc_sel_t;
	// serial clock phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_LOW,
		PH_HIGH
	} spimc_phase_t;
endpackage
`default_nettype wire

// ===== tb/spimc_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module spimc_far_end (
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic sel_n,
	output var  logic p_sck,
	output var  logic p_mosi,
	output var  logic p_miso,
	output var  logic p_miso_oe,
	output var  logic p_sel_n,
	output var  logic is_master
);
	logic [7:0] tx;
	logic [7:0] got;
	int         n;
	initial
	begin
		is_master = 1'b1;
		p_sck = 1'b0;
		p_mosi = 1'b0;
		p_miso = 1'b0;
		p_sel_n = 1'b1;
		tx = 8'h00;
		got = 8'h00;
		n = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// slave role: drive data only while addressed
	assign p_miso_oe = !is_master && !sel_n;
	always @(negedge sel_n)
		if (!is_master)
		begin
			n = 0;
			p_miso = tx[7];
		end
	always @(posedge sck)
		if (!is_master && !sel_n)
		begin
			got = {got[6:0], mosi};
			n = n + 1;
		end
	always @(negedge sck)
		if (!is_master && !sel_n)
			p_miso = (n < 8) ? tx[7 - n] : !p_miso;
	////////////////////////////////////////////////////////////////////////////////
	// master role: one byte, 200 ns clock, select low around it
	task automatic frame(input logic [7:0] b);
		#1;
		tx = b;
		p_mosi = b[7];
		p_sel_n = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--)
		begin
			p_sck = 1'b1;
			#50;
			got = {got[6:0], miso};
			#50;
			p_sck = 1'b0;
			if (i > 0)
				p_mosi = b[i - 1];
			#100;
		end
		p_sel_n = 1'b1;
		p_mosi = !p_mosi;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        stop_light = 1'b0;
	logic        stop_deep = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [3:0]  o_out;
	logic [3:0]  o_oe;
	logic [3:0]  claim;
	logic [3:0]  w;
	logic        p_sck;
	logic        p_mosi;
	logic        p_miso;
	logic        p_miso_oe;
	logic        p_sel_n;
	logic        p_mst;
	logic        fl = 1'b0;
	logic [7:0]  rnd = 8'h3a;
	logic [7:0]  b;
	logic [31:0] q;
	logic        perr;
	logic [7:0]  rx_q[$];
	int          errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////////////////////
	// pins: sck 3, mosi 2, miso 1, select 0; released lines toggle
	assign w[3] = o_oe[3] ? o_out[3] : p_mst ? p_sck : fl;
	assign w[2] = o_oe[2] ? o_out[2] : p_mst ? p_mosi : fl;
	assign w[1] = o_oe[1] ? o_out[1] : p_miso_oe ? p_miso : fl;
	assign w[0] = o_oe[0] ? o_out[0] : p_mst ? p_sel_n : fl;
	spimc_top dut (
		.pclk, .presetn, .ce, .stop_light, .stop_deep, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
		.serial_clock_pin_in(w[3]), .serial_clock_pin_out(o_out[3]),
		.serial_clock_pin_oe(o_oe[3]), .serial_clock_claim(claim[3]),
		.mosi_pin_in(w[2]), .mosi_pin_out(o_out[2]), .mosi_pin_oe(o_oe[2]), .mosi_claim(claim[2]),
		.miso_pin_in(w[1]), .miso_pin_out(o_out[1]), .miso_pin_oe(o_oe[1]), .miso_claim(claim[1]),
		.select_n_pin_in(w[0]), .select_n_pin_out(o_out[0]), .select_n_pin_oe(o_oe[0]),
		.select_claim(claim[0])
	);
	spimc_far_end far (
		.sck(w[3]), .mosi(w[2]), .miso(w[1]), .sel_n(w[0]), .p_sck, .p_mosi, .p_miso,
		.p_miso_oe, .p_sel_n, .is_master(p_mst)
	);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		fl <= ~fl;
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic stop_test();
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic irq_after(input logic [7:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		repeat (2) @(posedge pclk);
		check(irq, e);
	endtask
	task automatic wait_rx();
		int t;
		t = 0;
		do
		begin
			apb(1'b0, spimc_pkg::OFF_STAT, 32'h0);
			t++;
		end
		while (q[spimc_pkg::ST_RXF] !== 1'b1 && t < 200);
	endtask
	task automatic pins(input logic [4:0] c);
		logic       m;
		logic       sw;
		logic       dir;
		logic       fd;
		logic       so;
		logic [7:0] e;
		{so, fd, dir, sw, m} = c;
		wr(spimc_pkg::OFF_CTL2, {27'h0, fd, dir, 3'h0});
		wr(spimc_pkg::OFF_CTL1, {24'h0, 1'b0, 1'b1, 1'b0, m, 2'h0, so, sw});
		repeat (3) @(posedge pclk);
		e = {1'b1, m | !sw, !m | !sw, !m | fd, m, m & (!sw | dir), !m & sw & dir, m & fd & so};
		check({claim, o_oe}, e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(spimc_pkg::OFF_CTL1, 32'h0);
		rdc(spimc_pkg::OFF_STAT, 32'h20);
		check({claim, o_oe}, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(perr, 1'b1);
		for (int i = 0; i < 32; i++)
			pins(i[4:0]);
		// block as slave, partner as master
		wr(spimc_pkg::OFF_CTL2, 32'h0);
		wr(spimc_pkg::OFF_CTL1, 32'h40);
		rnd = lfsr(rnd);
		b = rnd;
		wr(spimc_pkg::OFF_DATA, {24'h0, b});
		rnd = lfsr(rnd);
		rx_q.push_back(rnd);
		far.frame(rnd);
		check(far.got, b);
		wait_rx();
		rdc(spimc_pkg::OFF_DATA, rx_q.pop_front());
		// block as master with select output
		wr(spimc_pkg::OFF_CTL2, 32'h10);
		wr(spimc_pkg::OFF_CTL1, 32'h52);
		wr(spimc_pkg::OFF_BAUD, 32'h2);
		apb(1'b0, spimc_pkg::OFF_EVT, 32'h0);
		far.is_master = 1'b0;
		rnd = lfsr(rnd);
		far.tx = rnd;
		rx_q.push_back(rnd);
		rnd = lfsr(rnd);
		wr(spimc_pkg::OFF_DATA, {24'h0, rnd});
		wait_rx();
		check(far.got, rnd);
		irq_after(spimc_pkg::OFF_CTL1, 32'hd2, 1'b1);
		irq_after(spimc_pkg::OFF_CTL1, 32'h72, 1'b1);
		irq_after(spimc_pkg::OFF_CTL1, 32'h52, 1'b0);
		irq_after(spimc_pkg::OFF_MASK, 32'h1, 1'b1);
		rdc(spimc_pkg::OFF_EVT, 32'h5);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
		rdc(spimc_pkg::OFF_DATA, rx_q.pop_front());
		// disable in mid-byte
		wr(spimc_pkg::OFF_BAUD, 32'hf);
		wr(spimc_pkg::OFF_DATA, {24'h0, rnd});
		repeat (20) @(posedge pclk);
		wr(spimc_pkg::OFF_CTL1, 32'h12);
		rdc(spimc_pkg::OFF_STAT, 32'h20);
		wr(spimc_pkg::OFF_CTL1, 32'h52);
		repeat (400) @(posedge pclk);
		rdc(spimc_pkg::OFF_STAT, 32'h20);
		far.is_master = 1'b1;
		// select pin as fault input
		wr(spimc_pkg::OFF_CTL1, 32'hd0);
		far.p_sel_n <= 1'b0;
		repeat (6) @(posedge pclk);
		far.p_sel_n <= 1'b1;
		rdc(spimc_pkg::OFF_STAT, 32'h30);
		check(irq, 1'b1);
		// stop modes
		rnd = lfsr(rnd);
		wr(spimc_pkg::OFF_CTL1, {24'h0, rnd & 8'hf3});
		stop_light <= 1'b1;
		repeat (5) @(posedge pclk);
		stop_light <= 1'b0;
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		rdc(spimc_pkg::OFF_CTL1, {24'h0, rnd & 8'hf3});
		stop_deep <= 1'b1;
		repeat (2) @(posedge pclk);
		stop_deep <= 1'b0;
		rdc(spimc_pkg::OFF_CTL1, 32'h0);
		rdc(spimc_pkg::OFF_STAT, 32'h20);
		stop_test();
	end
endmodule
`default_nettype wire
